// ### rtl/pao_pkg.sv
// Purpose: Shared constants and types of the phase accumulator oscillator
// Assumes: One 8-bit register per aligned 32-bit word on AXI4-Lite
// Notes: Offsets are byte addresses
`default_nettype none
package pao_pkg;

  // Datapath widths
  localparam int PAO_ACC_W = 20;
  localparam int PAO_INC_W = 16;
  localparam int PAO_ADDR_W = 8;
  localparam int PAO_PULSE_CNT_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_ACC_LOW = 8'h00;
  localparam logic [7:0] OFF_ACC_HIGH = 8'h04;
  localparam logic [7:0] OFF_ACC_UPPER = 8'h08;
  localparam logic [7:0] OFF_INC_LOW = 8'h0C;
  localparam logic [7:0] OFF_INC_HIGH = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam logic [7:0] OFF_CLK_CFG = 8'h18;

  // Control register fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_PIN_BIT = 6;
  localparam int CTRL_OUT_BIT = 5;
  localparam int CTRL_POL_BIT = 4;
  localparam int CTRL_PF_BIT = 0;

  // Clock configuration fields
  localparam int CLK_PW_LSB = 5;
  localparam int CLK_PW_W = 3;
  localparam int CLK_SEL_LSB = 0;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Accumulator clock sources, in select-field order
  typedef enum logic [1:0] {
    PAO_SRC_FAST,
    PAO_SRC_SYS,
    PAO_SRC_LOGIC,
    PAO_SRC_EXT
  } pao_src_t;

endpackage
`default_nettype wire

// ### rtl/pao_core_if.sv
// Purpose: Carrier between register front end and accumulator core
// Assumes: Both ends on aclk
// Notes: Write strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface pao_core_if #(
  parameter int ACC_W = pao_pkg::PAO_ACC_W,
  parameter int INC_W = pao_pkg::PAO_INC_W
);
  logic tick;
  logic enable;
  logic [7:0] wr_byte;
  logic inc_wr_low;
  logic inc_wr_high;
  logic [2:0] acc_wr;
  logic [INC_W-1:0] inc_sw;
  logic [ACC_W-1:0] acc;
  logic ovf;
  modport core (input tick, enable, wr_byte, inc_wr_low, inc_wr_high, acc_wr, inc_sw,
    output acc, ovf);
  modport ctl (output tick, enable, wr_byte, inc_wr_low, inc_wr_high, acc_wr, inc_sw,
    input acc, ovf);
endinterface
`default_nettype wire

// ### rtl/pao_accum.sv
// Purpose: Phase accumulator, adder and double-buffered increment
// Assumes: tick is a one-cycle pulse per selected input clock edge
// Notes: Software accumulator writes take priority over a tick
`timescale 1ns/1ps
`default_nettype none
module pao_accum #(
  parameter int ACC_W = pao_pkg::PAO_ACC_W,
  parameter int INC_W = pao_pkg::PAO_INC_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  pao_core_if.core c
);
  import pao_pkg::*;

  if (INC_W != 16 || ACC_W <= 16 || ACC_W > 24) begin : g_bad_width
    $error("pao_accum: unsupported widths");
  end

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [INC_W-1:0] active;
    logic pending;
    logic ovf;
  } pao_core_state_t;

  pao_core_state_t s;
  pao_core_state_t n;
  logic [ACC_W:0] sum;
  logic [ACC_W-1:0] exp_acc;

  // Adder runs freely; only the accumulator load is clocked
  assign sum = {1'b0, s.acc} + {{(ACC_W + 1 - INC_W){1'b0}}, s.active};
  assign exp_acc = sum[ACC_W-1:0];
  assign c.acc = s.acc;
  assign c.ovf = s.ovf;

  always_comb begin
    n = s;
    n.ovf = 1'b0;
    if (c.tick) begin
      n.acc = sum[ACC_W-1:0];
      n.ovf = sum[ACC_W];
    end
    if (c.acc_wr[0]) n.acc[7:0] = c.wr_byte;
    if (c.acc_wr[1]) n.acc[15:8] = c.wr_byte;
    if (c.acc_wr[2]) n.acc[ACC_W-1:16] = c.wr_byte[ACC_W-17:0];
    if (!c.enable) begin
      n.pending = 1'b0;
      if (c.inc_wr_low) n.active[7:0] = c.wr_byte;
      if (c.inc_wr_high) n.active[15:8] = c.wr_byte;
    end else begin
      // Both bytes move together on the accumulator clock
      if (c.tick && s.pending) begin
        n.active = c.inc_sw;
        n.pending = 1'b0;
      end
      if (c.inc_wr_low) n.pending = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) s <= '0;
    else s <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_acc_step;
    @(posedge aclk) disable iff (!aresetn)
    c.tick && (c.acc_wr == 3'h0) |=> s.acc == $past(exp_acc);
  endproperty
  a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong");

  property p_acc_hold;
    @(posedge aclk) disable iff (!aresetn)
    !c.tick && (c.acc_wr == 3'h0) |=> $stable(s.acc);
  endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("accumulator moved");

  property p_ovf;
    @(posedge aclk) disable iff (!aresetn)
    c.tick |=> s.ovf == $past(sum[ACC_W]);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");

  property p_imm_load;
    @(posedge aclk) disable iff (!aresetn)
    !c.enable && c.inc_wr_low |=> s.active[7:0] == $past(c.wr_byte);
  endproperty
  a_imm_load: assert property (p_imm_load) else $error("no immediate load");

  property p_sync_load;
    @(posedge aclk) disable iff (!aresetn)
    c.enable && s.pending && c.tick |=> s.active == $past(c.inc_sw);
  endproperty
  a_sync_load: assert property (p_sync_load) else $error("buffer not loaded");

  property p_inc_hold;
    @(posedge aclk) disable iff (!aresetn)
    c.enable && $past(c.enable) && !$past(c.tick) |-> $stable(s.active);
  endproperty
  a_inc_hold: assert property (p_inc_hold) else $error("increment changed");

  c_overflow: cover property (@(posedge aclk) disable iff (!aresetn) s.ovf);
endmodule
`default_nettype wire

// ### rtl/pao_top.sv
// Purpose: Phase accumulator oscillator with AXI4-Lite register access
// Assumes: Clock source inputs are synchronous to aclk
// Notes: Registers are 8 bits wide in the low byte of each word
`timescale 1ns/1ps
`default_nettype none

module pao_top #(
  parameter int ADDR_W = pao_pkg::PAO_ADDR_W,
  parameter int ACC_W = pao_pkg::PAO_ACC_W,
  parameter int INC_W = pao_pkg::PAO_INC_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic internal_fast_osc,
  input wire logic logic_cell_output,
  input wire logic external_clock_pin,
  output logic osc_out,
  output logic pin_out,
  output logic pin_oe,
  output logic overflow_event
);
  import pao_pkg::*;

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
    $error("pao_top: ADDR_W must be 8 to 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] waddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] inc_low;
    logic [7:0] inc_high;
    logic enable;
    logic pin_sel;
    logic polarity;
    logic pf_mode;
    pao_src_t clk_sel;
    logic [CLK_PW_W-1:0] pulse_w;
    logic [2:0] src_prev;
    logic toggle;
    logic pulse;
    logic [PAO_PULSE_CNT_W-1:0] pulse_cnt;
    logic osc_out;
    logic pin_out;
    logic pin_oe;
    logic ovf_event;
  } pao_top_state_t;

  pao_top_state_t s;
  pao_top_state_t n;

  pao_core_if #(.ACC_W(ACC_W), .INC_W(INC_W)) core_if ();

  pao_accum #(.ACC_W(ACC_W), .INC_W(INC_W)) u_accum (
    .aclk(aclk),
    .aresetn(aresetn),
    .c(core_if.core)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock source selection and edge detection
  logic [2:0] src_now;
  logic src_edge;
  logic tick;

  assign src_now = {external_clock_pin, logic_cell_output, internal_fast_osc};

  function automatic logic pick_edge(input pao_src_t sel, input logic [2:0] now,
                                     input logic [2:0] prev);
    logic e;
    e = 1'b0;
    unique case (sel)
      PAO_SRC_FAST: e = now[0] & ~prev[0];
      PAO_SRC_SYS: e = 1'b1;
      PAO_SRC_LOGIC: e = now[1] & ~prev[1];
      PAO_SRC_EXT: e = now[2] & ~prev[2];
    endcase
    return e;
  endfunction

  assign src_edge = pick_edge(s.clk_sel, src_now, s.src_prev);
  assign tick = s.enable & src_edge;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  logic do_write;
  logic wr_go;
  logic [7:0] woff;
  logic whit;
  logic [7:0] roff;
  logic rhit;

  function automatic logic in_map(input logic [ADDR_W-1:0] a);
    logic [7:0] off;
    off = {a[7:2], 2'b00};
    return ((a >> 8) == '0) && (off <= OFF_CLK_CFG);
  endfunction

  assign woff = {s.waddr[7:2], 2'b00};
  assign whit = in_map(s.waddr);
  assign roff = {s_axi_araddr[7:2], 2'b00};
  assign rhit = in_map(s_axi_araddr);
  assign do_write = s.aw_got & s.w_got & ~s.bvalid;
  assign wr_go = do_write & s.wstrb0 & whit;

  // Readback; the active increment buffer is not reachable
  function automatic logic [7:0] read_byte(input logic [7:0] off);
    logic [7:0] d;
    d = 8'h00;
    case (off)
      OFF_ACC_LOW: d = core_if.acc[7:0];
      OFF_ACC_HIGH: d = core_if.acc[15:8];
      OFF_ACC_UPPER: d[ACC_W-17:0] = core_if.acc[ACC_W-1:16];
      OFF_INC_LOW: d = s.inc_low;
      OFF_INC_HIGH: d = s.inc_high;
      OFF_CTRL: begin
        d[CTRL_EN_BIT] = s.enable;
        d[CTRL_PIN_BIT] = s.pin_sel;
        d[CTRL_OUT_BIT] = s.osc_out;
        d[CTRL_POL_BIT] = s.polarity;
        d[CTRL_PF_BIT] = s.pf_mode;
      end
      OFF_CLK_CFG: begin
        d[CLK_PW_LSB +: CLK_PW_W] = s.pulse_w;
        d[CLK_SEL_LSB +: 2] = s.clk_sel;
      end
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Core connections
  assign core_if.tick = tick;
  assign core_if.enable = s.enable;
  assign core_if.wr_byte = s.wdata;
  assign core_if.inc_sw = {s.inc_high, s.inc_low};
  assign core_if.inc_wr_low = wr_go && (woff == OFF_INC_LOW);
  assign core_if.inc_wr_high = wr_go && (woff == OFF_INC_HIGH);
  assign core_if.acc_wr[0] = wr_go && (woff == OFF_ACC_LOW);
  assign core_if.acc_wr[1] = wr_go && (woff == OFF_ACC_HIGH);
  assign core_if.acc_wr[2] = wr_go && (woff == OFF_ACC_UPPER);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = s;
    n.src_prev = src_now;
    n.ovf_event = core_if.ovf;
    // Write channel
    if (s.awready && s_axi_awvalid) begin
      n.aw_got = 1'b1;
      n.waddr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata[7:0];
      n.wstrb0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) n.bvalid = 1'b0;
    if (do_write) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = whit ? RESP_OKAY : RESP_SLVERR;
    end
    if (wr_go) begin
      case (woff)
        OFF_INC_LOW: n.inc_low = s.wdata;
        OFF_INC_HIGH: n.inc_high = s.wdata;
        OFF_CTRL: begin
          n.enable = s.wdata[CTRL_EN_BIT];
          n.pin_sel = s.wdata[CTRL_PIN_BIT];
          n.polarity = s.wdata[CTRL_POL_BIT];
          n.pf_mode = s.wdata[CTRL_PF_BIT];
        end
        OFF_CLK_CFG: begin
          n.pulse_w = s.wdata[CLK_PW_LSB +: CLK_PW_W];
          n.clk_sel = pao_src_t'(s.wdata[CLK_SEL_LSB +: 2]);
        end
        default: n.enable = s.enable;
      endcase
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    // Read channel
    if (s.rvalid && s_axi_rready) n.rvalid = 1'b0;
    if (s.arready && s_axi_arvalid) begin
      n.rvalid = 1'b1;
      n.rdata = {24'h000000, read_byte(roff)};
      n.rresp = rhit ? RESP_OKAY : RESP_SLVERR;
    end
    n.arready = !n.rvalid;
    // Output shaping of the raw carry
    if (!s.enable) begin
      n.pulse = 1'b0;
    end else if (core_if.ovf) begin
      if (s.pf_mode) begin
        n.pulse = 1'b1;
        n.pulse_cnt = PAO_PULSE_CNT_W'((9'h001 << s.pulse_w) - 9'h001);
      end else begin
        n.toggle = ~s.toggle;
      end
    end else if (s.pulse && tick) begin
      // Width counted in selected input clock periods
      if (s.pulse_cnt == '0) n.pulse = 1'b0;
      else n.pulse_cnt = s.pulse_cnt - 1'b1;
    end
    n.osc_out = (n.pf_mode ? n.pulse : n.toggle) ^ n.polarity;
    n.pin_out = n.osc_out;
    n.pin_oe = n.enable & n.pin_sel;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) s <= '0;
    else s <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign osc_out = s.osc_out;
  assign pin_out = s.pin_out;
  assign pin_oe = s.pin_oe;
  assign overflow_event = s.ovf_event;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_sys_tick;
    @(posedge aclk) disable iff (!aresetn)
    s.enable && (s.clk_sel == PAO_SRC_SYS) |-> tick;
  endproperty
  a_sys_tick: assert property (p_sys_tick) else $error("system clock not ticking");

  property p_ext_edge;
    @(posedge aclk) disable iff (!aresetn)
    s.enable && (s.clk_sel == PAO_SRC_EXT) && external_clock_pin
      && !$past(external_clock_pin) && $past(aresetn) |-> tick;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("pin edge missed");

  property p_ovf_event;
    @(posedge aclk) disable iff (!aresetn)
    core_if.ovf |=> overflow_event;
  endproperty
  a_ovf_event: assert property (p_ovf_event) else $error("overflow event lost");

  property p_fdc_toggle;
    @(posedge aclk) disable iff (!aresetn)
    core_if.ovf && s.enable && !s.pf_mode |=> s.toggle != $past(s.toggle);
  endproperty
  a_fdc_toggle: assert property (p_fdc_toggle) else $error("no toggle");

  property p_pf_pulse;
    @(posedge aclk) disable iff (!aresetn)
    core_if.ovf && s.enable && s.pf_mode && !do_write |=> osc_out != s.polarity;
  endproperty
  a_pf_pulse: assert property (p_pf_pulse) else $error("no pulse");

  property p_pin;
    @(posedge aclk) disable iff (!aresetn)
    pin_oe |-> pin_out == osc_out;
  endproperty
  a_pin: assert property (p_pin) else $error("pin differs from output");

  property p_rd_resp;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read not answered");

  property p_inc_read;
    @(posedge aclk) disable iff (!aresetn)
    core_if.inc_wr_high |=> s.inc_high == $past(s.wdata) ##1 1'b1;
  endproperty
  a_inc_read: assert property (p_inc_read) else $error("increment byte lost");

  c_write: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
  c_read: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
  c_pulse: cover property (@(posedge aclk) disable iff (!aresetn) s.pulse && s.pf_mode);
  c_toggle: cover property (@(posedge aclk) disable iff (!aresetn) core_if.ovf && !s.pf_mode);
endmodule
`default_nettype wire

// ### verif/test_phase_accumulator_oscillator.sv
// Purpose: Self-checking bench for the phase accumulator oscillator top
// Assumes: Clock source inputs are driven synchronously to aclk
// Notes: Accumulator reads are taken while the selected source is idle
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_phase_accumulator_oscillator;
  import pao_pkg::*;
  localparam logic [7:0] EN = 8'h01 << CTRL_EN_BIT;
  localparam logic [7:0] PIN = 8'h01 << CTRL_PIN_BIT;
  localparam logic [7:0] POL = 8'h01 << CTRL_POL_BIT;
  localparam logic [7:0] PF = 8'h01 << CTRL_PF_BIT;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, osc_out, pin_out, pin_oe, ovf_ev;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [2:0] clk_in;
  int err_count, n_checks, ovf_cnt;

  pao_top dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .internal_fast_osc(clk_in[0]), .logic_cell_output(clk_in[1]),
    .external_clock_pin(clk_in[2]), .osc_out(osc_out), .pin_out(pin_out),
    .pin_oe(pin_oe), .overflow_event(ovf_ev)
  );

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (ovf_ev === 1'b1) ovf_cnt <= ovf_cnt + 1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus and stimulus helpers
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    logic aw_ok, w_ok;
    @(posedge aclk);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= s;
    bready <= 1'b1;
    // Only the watchdog ends a wait for the slave
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, 4'h1, r);
    `CHK(r, RESP_OKAY)
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    `CHK(d, {24'h0, e})
    `CHK(r, RESP_OKAY)
  endtask

  task automatic set_acc(input logic [19:0] v);
    wr(OFF_ACC_LOW, v[7:0]);
    wr(OFF_ACC_HIGH, v[15:8]);
    wr(OFF_ACC_UPPER, {4'h0, v[19:16]});
  endtask

  task automatic get_acc(output logic [19:0] v);
    logic [31:0] d0, d1, d2;
    logic [1:0] r;
    axi_rd(OFF_ACC_LOW, d0, r);
    axi_rd(OFF_ACC_HIGH, d1, r);
    axi_rd(OFF_ACC_UPPER, d2, r);
    v = {d2[3:0], d1[7:0], d0[7:0]};
  endtask

  // High byte first so the pair lands as one value
  task automatic set_inc(input logic [15:0] v);
    wr(OFF_INC_HIGH, v[15:8]);
    wr(OFF_INC_LOW, v[7:0]);
  endtask

  // One rising edge on a source input, then time for the output pipeline
  task automatic tick(input int k);
    @(posedge aclk);
    clk_in[k] <= 1'b1;
    @(posedge aclk);
    clk_in[k] <= 1'b0;
    repeat (5) @(posedge aclk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 7; i++) rd(8'(4 * i), 8'h00);
    axi_rd(8'h1C, d, r);
    `CHK(d, 32'h0)
    `CHK(r, RESP_SLVERR)
    axi_wr(8'h1C, 8'h55, 4'h1, r);
    `CHK(r, RESP_SLVERR)
    axi_wr(OFF_INC_HIGH, 8'h5A, 4'h0, r);
    `CHK(r, RESP_OKAY)
    rd(OFF_INC_HIGH, 8'h00);
  endtask

  task automatic t_acc();
    set_acc(20'hABCDE);
    rd(OFF_ACC_LOW, 8'hDE);
    rd(OFF_ACC_HIGH, 8'hBC);
    rd(OFF_ACC_UPPER, 8'h0A);
    wr(OFF_ACC_UPPER, 8'hFF);
    rd(OFF_ACC_UPPER, 8'h0F);
  endtask

  // Every source in turn; ticks on the other inputs must be ignored
  task automatic t_src();
    logic [19:0] v;
    for (int s = 0; s < 4; s++) begin
      wr(OFF_CLK_CFG, 8'(s));
      set_acc(20'h0);
      set_inc(16'h0103);
      wr(OFF_CTRL, EN);
      for (int k = 0; k < 3; k++) begin
        tick(k);
        tick(k);
      end
      wr(OFF_CTRL, 8'h00);
      get_acc(v);
      if (s == 1) begin
        `CHK(v != 20'h0 && v % 20'h00103 == 0, 1'b1)
      end else begin
        `CHK(v, 20'h00206)
      end
    end
  endtask

  task automatic t_ovf();
    logic [19:0] v;
    logic o0;
    int c0;
    wr(OFF_CLK_CFG, 8'h03);
    set_inc(16'h0010);
    set_acc(20'hFFFF8);
    wr(OFF_CTRL, EN | PIN);
    repeat (2) @(posedge aclk);
    o0 = osc_out;
    c0 = ovf_cnt;
    tick(2);
    get_acc(v);
    `CHK(v, 20'h00008)
    `CHK(ovf_cnt - c0, 1)
    `CHK(osc_out, ~o0)
    `CHK(pin_out, osc_out)
    `CHK(pin_oe, 1'b1)
    rd(OFF_CTRL, EN | PIN | (8'h01 << CTRL_OUT_BIT));
    tick(2);
    get_acc(v);
    `CHK(v, 20'h00018)
    `CHK(ovf_cnt - c0, 1)
    `CHK(osc_out, ~o0)
    wr(OFF_CTRL, EN | POL);
    repeat (2) @(posedge aclk);
    `CHK(pin_oe, 1'b0)
    `CHK(osc_out, o0)
    wr(OFF_CTRL, 8'h00);
  endtask

  // Increment change while running: only the low-byte write arms the load
  task automatic t_buf();
    logic [19:0] a1, a2;
    wr(OFF_CLK_CFG, 8'h03);
    set_inc(16'h0001);
    set_acc(20'h0);
    wr(OFF_CTRL, EN);
    wr(OFF_INC_HIGH, 8'h02);
    tick(2);
    get_acc(a1);
    `CHK(a1, 20'h00001)
    rd(OFF_INC_HIGH, 8'h02);
    wr(OFF_INC_LOW, 8'h00);
    rd(OFF_INC_LOW, 8'h00);
    tick(2);
    get_acc(a1);
    tick(2);
    get_acc(a2);
    `CHK(a2 - a1, 20'h00200)
    wr(OFF_CTRL, 8'h00);
  endtask

  // Pulse mode with width exponent 2: four input periods high
  task automatic t_pf();
    wr(OFF_CLK_CFG, 8'h43);
    rd(OFF_CLK_CFG, 8'h43);
    set_inc(16'h0010);
    set_acc(20'hFFFF8);
    wr(OFF_CTRL, EN | PF);
    repeat (2) @(posedge aclk);
    `CHK(osc_out, 1'b0)
    tick(2);
    `CHK(osc_out, 1'b1)
    repeat (3) tick(2);
    `CHK(osc_out, 1'b1)
    repeat (2) tick(2);
    `CHK(osc_out, 1'b0)
    wr(OFF_CTRL, 8'h00);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Run control
  task automatic close_out();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    close_out();
  end

  initial begin
    err_count = 0;
    n_checks = 0;
    ovf_cnt = 0;
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    clk_in = 3'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_acc();
    t_src();
    t_ovf();
    t_buf();
    t_pf();
    close_out();
  end
endmodule
`default_nettype wire
